// file: bench/hbr_regs_tb_top.sv
// Self-checking bench for the bridge driver register bank
`timescale 1ns/100ps
module hbr_regs_tb_top;
  import hbr_pkg::*;
  localparam logic [7:0] RST_TAB [6] = '{8'h00, 8'h00, 8'h51, 8'h0C, 8'h40, 8'h08};
  localparam logic [7:0] WR_TAB [6] = '{8'h00, 8'h00, 8'h96, 8'hA5, 8'hCC, 8'hD6};
  localparam logic [7:0] FLT_TAB [12] = '{8'h44, 8'h44, 8'h44, 8'h44, 8'h00, 8'h00,
                                          8'h41, 8'h41, 8'h42, 8'h48, 8'h50, 8'h20};
  localparam logic [7:0] DIAG_TAB [12] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20,
                                           8'h40, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
  logic        sys_clk;
  logic        rst;
  logic        spi_sclk;
  logic        spi_cs_n;
  logic        spi_sdi;
  logic        spi_sdo;
  logic        spi_sdo_oe;
  hbr_detect_t detect;
  logic        drive_pin_a;
  logic        drive_pin_b;
  logic        fault_indication_pin_n;
  hbr_bridge_t bridge;
  hbr_config_t config_out;
  int          err_total;
  int          checks_done;
  logic [15:0] rep;
  logic [7:0]  dat;
  logic [3:0]  br;

  hbr_spi_master i_master (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
                           .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe));
  hbr_regs i_dut (.sys_clk(sys_clk), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
                  .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .detect(detect),
                  .drive_pin_a(drive_pin_a), .drive_pin_b(drive_pin_b),
                  .fault_indication_pin_n(fault_indication_pin_n), .bridge(bridge),
                  .config_out(config_out));

  always #12.5 sys_clk = ~sys_clk;

  task automatic results();
    $display("mismatches %0d of %0d checks", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: pins %b, wanted %b", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    i_master.xfer({2'b01, a, 9'h000}, 16, rep);
    d = rep[7:0];
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    i_master.xfer({2'b00, a, 1'b0, d}, 16, rep);
  endtask

  function automatic logic [3:0] exp_br(input int m, input logic a, input logic b, input logic da,
                                        input logic db);
    case (m)
      0: return {1'b1, a & b, 1'b1, a & ~b};
      1: return {1'b1, a, 1'b1, b};
      2: return {~da, a, ~db, b};
      default: return 4'h0;
    endcase
  endfunction

  initial begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    $display("unexpected at %0t: run hung", $time);
    results();
  end

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    detect = '0;
    drive_pin_a = 1'b0;
    drive_pin_b = 1'b0;
    err_total = 0;
    checks_done = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    for (int a = 0; a < 6; a++) begin
      rd(a[4:0], dat);
      chk8(dat, RST_TAB[a]);
    end
    chkb({spi_sdo, spi_sdo_oe, i_master.oe_seen, 1'b0}, 4'hA);
    rd(5'h07, dat);
    chk8(dat, 8'h00);
    for (int a = 2; a < 6; a++) begin
      wr(a[4:0], WR_TAB[a]);
      chk8(rep[7:0], RST_TAB[a]);
      rd(a[4:0], dat);
      chk8(dat, WR_TAB[a] & ((a == 4) ? 8'h7F : 8'hFF));
    end
    chk8(config_out.prot, 8'hA5);
    for (int a = 0; a < 2; a++) begin
      wr(a[4:0], 8'hFF);
      rd(a[4:0], dat);
      chk8(dat, 8'h00);
    end
    i_master.xfer({2'b00, HBR_ADDR_PROT, 1'b0, 8'h11}, 15, rep);
    i_master.xfer({2'b00, HBR_ADDR_PROT, 1'b0, 8'h11}, 17, rep);
    rd(HBR_ADDR_PROT, dat);
    chk8(dat, 8'hA5);
    wr(HBR_ADDR_PROT, 8'h00);
    wr(HBR_ADDR_OUT, 8'h40);
    for (int i = 0; i < 12; i++) begin
      @(posedge sys_clk) detect <= hbr_detect_t'(12'h001 << i);
      repeat (10) @(posedge sys_clk);
      chkb({3'h0, fault_indication_pin_n}, {3'h0, ~FLT_TAB[i][6]});
      rd(HBR_ADDR_FAULT, dat);
      chk8(dat, FLT_TAB[i]);
      chk8(rep[15:8], {2'h3, FLT_TAB[i][5:0]});
      rd(HBR_ADDR_DIAG, dat);
      chk8(dat, DIAG_TAB[i]);
      @(posedge sys_clk) detect <= '0;
      repeat (10) @(posedge sys_clk);
      wr(HBR_ADDR_OUT, 8'hC0);
      rd(HBR_ADDR_FAULT, dat);
      chk8(dat, 8'h00);
      rd(HBR_ADDR_DIAG, dat);
      chk8(dat, 8'h00);
    end
    wr(HBR_ADDR_PROT, 8'hF3);
    @(posedge sys_clk) detect <= hbr_detect_t'(12'hFFF);
    repeat (10) @(posedge sys_clk);
    chkb({3'h0, fault_indication_pin_n}, 4'h0);
    rd(HBR_ADDR_FAULT, dat);
    chk8(dat, 8'h73);
    rd(HBR_ADDR_DIAG, dat);
    chk8(dat, 8'hF0);
    @(posedge sys_clk) detect <= '0;
    repeat (10) @(posedge sys_clk);
    rd(HBR_ADDR_FAULT, dat);
    chk8(dat, 8'h71);
    wr(HBR_ADDR_OUT, 8'hC0);
    @(posedge sys_clk) detect <= hbr_detect_t'(12'h020);
    repeat (10) @(posedge sys_clk);
    rd(HBR_ADDR_FAULT, dat);
    chk8(dat, 8'h40);
    @(posedge sys_clk) detect <= hbr_detect_t'(12'h800);
    repeat (10) @(posedge sys_clk);
    rd(HBR_ADDR_FAULT, dat);
    chk8(dat, 8'h60);
    @(posedge sys_clk) detect <= '0;
    wr(HBR_ADDR_OUT, 8'hC0);
    wr(HBR_ADDR_PROT, 8'h00);
    wr(HBR_ADDR_OUT, 8'h30);
    wr(HBR_ADDR_DRIVE, 8'h00);
    rd(HBR_ADDR_DRIVE, dat);
    chk8(dat, 8'h96);
    rd(HBR_ADDR_OUT, dat);
    chk8(dat, 8'h30);
    wr(HBR_ADDR_OUT, 8'h40);
    wr(HBR_ADDR_DRIVE, 8'h00);
    rd(HBR_ADDR_DRIVE, dat);
    chk8(dat, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(HBR_ADDR_DRIVE, {6'h08, m[1:0]});
      for (int ab = 0; ab < 4; ab++) begin
        wr(HBR_ADDR_OUT, {4'h4, ab == 3, ab == 0, ab[1:0]});
        repeat (3) @(posedge sys_clk);
        br = bridge;
        if (m == 3)
          br = br & 4'hA;
        chkb(br, exp_br(m, ab[1], ab[0], ab == 3, ab == 0));
      end
    end
    wr(HBR_ADDR_DRIVE, 8'h01);
    @(posedge sys_clk) drive_pin_a <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chkb(bridge, 4'hE);
    @(posedge sys_clk) drive_pin_b <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chkb(bridge, 4'hF);
    // Mid-run reset with a latched flag
    @(posedge sys_clk) detect <= hbr_detect_t'(12'h800);
    repeat (10) @(posedge sys_clk);
    detect <= '0;
    rst    <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chkb({3'h0, fault_indication_pin_n}, 4'h1);
    rd(HBR_ADDR_FAULT, dat);
    chk8(dat, 8'h00);
    rd(HBR_ADDR_DRIVE, dat);
    chk8(dat, 8'h51);
    results();
  end
endmodule // hbr_regs_tb_top

// file: bench/hbr_spi_master.sv
// Serial link master model standing in for the host controller
`timescale 1ns/100ps
module hbr_spi_master (
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_sdi,
  input  wire logic spi_sdo,
  input  wire logic spi_sdo_oe
);
  logic oe_seen;

  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi  = 1'b0;
    oe_seen  = 1'b0;
  end

  // One frame of nedge clocks; reply bit taken just ahead of each of the first 16 rising edges
  task automatic xfer(input logic [15:0] word, input int nedge, output logic [15:0] reply);
    reply = 16'h0;
    if (!word[14] && word[13:9] > 5'h05) begin
      return;
    end
    #7 spi_cs_n = 1'b0;
    #128;
    oe_seen = spi_sdo_oe;
    for (int i = 0; i < nedge; i++) begin
      spi_sdi = (i < 16) ? word[15-i] : ~word[0];
      if (i < 16) begin
        reply[15-i] = spi_sdo;
      end
      #24 spi_sclk = 1'b1;
      #32 spi_sclk = 1'b0;
      #8;
    end
    #24 spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi;
    #600;
  endtask
endmodule // hbr_spi_master

// file: hw/hbr_pkg.sv
// Shared constants, register layouts and frame format of the bridge driver register bank
// Notes on behaviour
// RQ1 - Host leaves unlisted addresses alone, never writes them
// RQ2 - Addresses 0x00 and 0x01 are read-only status
// RQ3 - Summary bit 6 mirrors fault pin; bit 7 zero
// RQ4 - Summary bits 5..0: warning, supply, pump, overcurrent, thermal, load
// RQ5 - Diagnostic bits 7, 6: open load on bridges
// RQ6 - Diagnostic bit 5 live regulation of output 1
// RQ7 - Diagnostic bit 4 live regulation of output 2
// RQ8 - Diagnostic bits 3..0: per-switch overcurrent flags
// RQ9 - Every status bit clears to zero on reset
// RQ10 - Addresses 0x02 to 0x05 read and write
// RQ11 - Drive config: off time, serial select, slew, mode
// RQ12 - Protection config fields packed from bit 7 down
// RQ13 - Output control: clear, lock, disables, serial bits
// RQ14 - Load check config: reserved, checks, trip fields
// RQ15 - Mode field picks input scheme or high impedance
// RQ16 - Fault clear empties latched flags, reads zero
// RQ17 - Lock code freezes drive config; unlock code frees
// RQ18 - Serial select routes serial drive bits to outputs
// RQ19 - Writes to status addresses change nothing
package hbr_pkg;

  localparam int unsigned HBR_ADDR_W   = 5;
  localparam int unsigned HBR_DATA_W   = 8;
  localparam int unsigned HBR_FRAME_W  = 16;
  localparam int unsigned HBR_NUM_REGS = 6;

  localparam logic [4:0] HBR_ADDR_FAULT = 5'h00;
  localparam logic [4:0] HBR_ADDR_DIAG  = 5'h01;
  localparam logic [4:0] HBR_ADDR_DRIVE = 5'h02;
  localparam logic [4:0] HBR_ADDR_PROT  = 5'h03;
  localparam logic [4:0] HBR_ADDR_OUT   = 5'h04;
  localparam logic [4:0] HBR_ADDR_LOAD  = 5'h05;

  // Frame layout
  localparam int unsigned HBR_RW_BIT   = 14;
  localparam int unsigned HBR_ADDR_MSB = 13;
  localparam int unsigned HBR_ADDR_LSB = 9;
  localparam logic [1:0]  HBR_STATUS_TAG = 2'h3;

  // Link-side edge counts
  localparam logic [4:0] HBR_FALL_LAST = 5'h0F;
  localparam logic [4:0] HBR_FALL_OVER = 5'h10;
  localparam logic [4:0] HBR_FALL_SAT  = 5'h11;
  localparam logic [3:0] HBR_RISE_ADDR = 4'h7;
  localparam logic [3:0] HBR_RISE_LAST = 4'hE;
  localparam logic [3:0] HBR_RISE_SAT  = 4'hF;

  localparam logic [2:0] HBR_LOCK_ON  = 3'h3;
  localparam logic [2:0] HBR_LOCK_OFF = 3'h4;
  localparam logic [1:0] HBR_OC_SILENT = 2'h3;

  typedef enum logic [1:0] {
    HBR_MODE_PH_EN  = 2'h0,
    HBR_MODE_TWO_IN = 2'h1,
    HBR_MODE_INDEP  = 2'h2,
    HBR_MODE_OFF    = 2'h3
  } hbr_mode_t;

  typedef struct packed {
    logic       reserved_bit;
    logic       global_fault;
    logic       overtemp_warning_flag;
    logic       supply_undervoltage_flag;
    logic       pump_undervoltage_flag;
    logic       overcurrent_flag;
    logic       thermal_shutdown_flag;
    logic       open_load_flag;
  } hbr_fault_t;

  typedef struct packed {
    logic       open_load_bridge_a;
    logic       open_load_bridge_b;
    logic       regulating_bridge_a;
    logic       regulating_bridge_b;
    logic       overcurrent_high_a;
    logic       overcurrent_low_a;
    logic       overcurrent_high_b;
    logic       overcurrent_low_b;
  } hbr_diag_t;

  typedef struct packed {
    logic [1:0] off_time_select;
    logic       serial_input_select;
    logic [2:0] slew_rate_select;
    hbr_mode_t  control_mode;
  } hbr_drive_t;

  typedef struct packed {
    logic       trip_report_enable;
    logic       thermal_recovery_mode;
    logic       warning_report_enable;
    logic       pump_fault_disable;
    logic [1:0] overcurrent_retry_time;
    logic [1:0] overcurrent_response;
  } hbr_prot_t;

  typedef struct packed {
    logic       fault_clear;
    logic [2:0] lock_code;
    logic       bridge_a_disable;
    logic       bridge_b_disable;
    logic       serial_drive_bit_a;
    logic       serial_drive_bit_b;
  } hbr_outctl_t;

  typedef struct packed {
    logic       reserved_bit;
    logic       passive_load_check_enable;
    logic       passive_load_check_delay;
    logic       active_load_check_enable;
    logic [1:0] trip_level;
    logic [1:0] trip_disable;
  } hbr_load_t;

  typedef struct packed {
    hbr_drive_t  drive;
    hbr_prot_t   prot;
    hbr_outctl_t outctl;
    hbr_load_t   load;
  } hbr_config_t;

  // Raw detector levels, asynchronous to sys_clk
  typedef struct packed {
    logic       overtemp_warning;
    logic       supply_undervoltage;
    logic       pump_undervoltage;
    logic       thermal_shutdown;
    logic       open_load_a;
    logic       open_load_b;
    logic       regulating_a;
    logic       regulating_b;
    logic       overcurrent_high_a;
    logic       overcurrent_low_a;
    logic       overcurrent_high_b;
    logic       overcurrent_low_b;
  } hbr_detect_t;

  typedef struct packed {
    logic       a_driven;
    logic       a_high;
    logic       b_driven;
    logic       b_high;
  } hbr_bridge_t;

  localparam hbr_drive_t HBR_DRIVE_RST = '{off_time_select: 2'h1, serial_input_select: 1'h0,
                                           slew_rate_select: 3'h4, control_mode: HBR_MODE_TWO_IN};
  localparam hbr_prot_t HBR_PROT_RST = '{trip_report_enable: 1'h0, thermal_recovery_mode: 1'h0,
                                         warning_report_enable: 1'h0, pump_fault_disable: 1'h0,
                                         overcurrent_retry_time: 2'h3, overcurrent_response: 2'h0};
  localparam hbr_outctl_t HBR_OUT_RST = '{fault_clear: 1'h0, lock_code: 3'h4, bridge_a_disable: 1'h0,
                                          bridge_b_disable: 1'h0, serial_drive_bit_a: 1'h0,
                                          serial_drive_bit_b: 1'h0};
  localparam hbr_load_t HBR_LOAD_RST = '{reserved_bit: 1'h0, passive_load_check_enable: 1'h0,
                                         passive_load_check_delay: 1'h0, active_load_check_enable: 1'h0,
                                         trip_level: 2'h2, trip_disable: 2'h0};

  function automatic logic hbr_mapped(input logic [4:0] addr);
    return addr <= HBR_ADDR_LOAD;
  endfunction

endpackage

// file: hw/hbr_regs.sv
// Bridge driver register bank with serial link slave and output steering
`timescale 1ns/100ps
module hbr_regs
  import hbr_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sdi,
  output logic             spi_sdo,
  output logic             spi_sdo_oe,
  input  wire hbr_detect_t detect,
  input  wire logic        drive_pin_a,
  input  wire logic        drive_pin_b,
  output logic             fault_indication_pin_n,
  output hbr_bridge_t      bridge,
  output hbr_config_t      config_out
);

  // ---------------- Link domain, receive on falling edge ----------------
  logic [4:0]  lk_fall_q;
  logic [15:0] lk_shift_q;
  logic [15:0] lk_word_q;
  logic        lk_done_tgl_q;
  logic        lk_err_tgl_q;
  logic [7:0]  snap_q [0:HBR_NUM_REGS-1];

  wire logic [4:0]  lk_fall_d  = (lk_fall_q == HBR_FALL_SAT) ? HBR_FALL_SAT : lk_fall_q + 5'h01;
  wire logic [15:0] lk_shift_d = {lk_shift_q[14:0], spi_sdi};

  always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      lk_fall_q  <= 5'h00;
      lk_shift_q <= 16'h0000;
    end else begin
      lk_fall_q  <= lk_fall_d;
      lk_shift_q <= lk_shift_d;
    end
  end

  // Word and toggles outlive the frame; sys side samples them after select rises
  always_ff @(negedge spi_sclk or posedge rst) begin
    if (rst) begin
      lk_word_q     <= 16'h0000;
      lk_done_tgl_q <= 1'b0;
      lk_err_tgl_q  <= 1'b0;
    end else begin
      if (!spi_cs_n && lk_fall_q == HBR_FALL_LAST) begin
        lk_word_q     <= lk_shift_d;
        lk_done_tgl_q <= ~lk_done_tgl_q;
      end
      if (!spi_cs_n && lk_fall_q == HBR_FALL_OVER)
        lk_err_tgl_q <= ~lk_err_tgl_q;
    end
  end

  // ---------------- Link domain, transmit on rising edge ----------------
  logic [3:0] lk_rise_q;
  logic [4:0] lk_addr_q;
  logic       lk_sdo_q;

  wire logic [4:0]  lk_addr    = (lk_rise_q == HBR_RISE_ADDR) ? lk_shift_q[4:0] : lk_addr_q;
  wire logic [7:0]  lk_report  = hbr_mapped(lk_addr) ? snap_q[lk_addr[2:0]] : 8'h00;
  wire logic [15:0] lk_tx_word = {HBR_STATUS_TAG, snap_q[HBR_ADDR_FAULT[2:0]][5:0], lk_report};
  wire logic [3:0]  lk_tx_idx  = HBR_RISE_LAST - lk_rise_q;
  wire logic        lk_tx_bit  = (lk_rise_q <= HBR_RISE_LAST) ? lk_tx_word[lk_tx_idx] : 1'b0;

  always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      lk_rise_q <= 4'h0;
      lk_addr_q <= 5'h00;
      lk_sdo_q  <= 1'b1;
    end else begin
      lk_rise_q <= (lk_rise_q == HBR_RISE_SAT) ? HBR_RISE_SAT : lk_rise_q + 4'h1;
      lk_addr_q <= lk_addr;
      lk_sdo_q  <= lk_tx_bit;
    end
  end

  assign spi_sdo    = lk_sdo_q;
  assign spi_sdo_oe = ~spi_cs_n;

  // ---------------- Crossings into sys_clk ----------------
  logic        cs_s;
  logic        done_s;
  logic        err_s;
  logic        pin_a_s;
  logic        pin_b_s;
  hbr_detect_t det_s;

  hbr_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_cs (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (spi_cs_n),
    .sync_out (cs_s)
  );
  hbr_sync #(.WIDTH(4), .RST_VAL(4'h0)) u_sync_lvl (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({lk_done_tgl_q, lk_err_tgl_q, drive_pin_a, drive_pin_b}),
    .sync_out ({done_s, err_s, pin_a_s, pin_b_s})
  );
  hbr_sync #(.WIDTH($bits(hbr_detect_t)), .RST_VAL('0)) u_sync_det (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (detect),
    .sync_out (det_s)
  );

  // ---------------- Frame commit ----------------
  logic cs_prev_q;
  logic eval_q;
  logic done_seen_q;
  logic err_seen_q;

  wire logic       cs_rise  = cs_s & ~cs_prev_q;
  wire logic       frame_ok = eval_q & (done_s ^ done_seen_q) & ~(err_s ^ err_seen_q);
  wire logic       wr       = frame_ok & ~lk_word_q[HBR_RW_BIT];
  wire logic [4:0] waddr    = lk_word_q[HBR_ADDR_MSB:HBR_ADDR_LSB];
  wire logic [7:0] wdata    = lk_word_q[HBR_DATA_W-1:0];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cs_prev_q   <= 1'b1;
      eval_q      <= 1'b0;
      done_seen_q <= 1'b0;
      err_seen_q  <= 1'b0;
    end else begin
      cs_prev_q <= cs_s;
      eval_q    <= cs_rise;
      if (eval_q) begin
        done_seen_q <= done_s;
        err_seen_q  <= err_s;
      end
    end
  end

  // ---------------- Control registers ----------------
  hbr_drive_t  drive_q;
  hbr_prot_t   prot_q;
  hbr_outctl_t outctl_q;
  hbr_load_t   load_q;
  logic        locked_q;

  // Only the four configuration addresses decode; status addresses fall through
  wire logic  wr_drive = wr & (waddr == HBR_ADDR_DRIVE) & ~locked_q; // see RQ10, see RQ17, see RQ19
  wire logic  wr_prot  = wr & (waddr == HBR_ADDR_PROT);
  wire logic  wr_out   = wr & (waddr == HBR_ADDR_OUT);
  wire logic  wr_load  = wr & (waddr == HBR_ADDR_LOAD);
  wire logic  clr_pls  = wr_out & wdata[7]; // see RQ16
  wire hbr_outctl_t out_wr = {1'b0, wdata[6:0]}; // see RQ13, see RQ16

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drive_q  <= HBR_DRIVE_RST;
      prot_q   <= HBR_PROT_RST;
      outctl_q <= HBR_OUT_RST;
      load_q   <= HBR_LOAD_RST;
      locked_q <= 1'b0;
    end else begin
      if (wr_drive)
        drive_q <= hbr_drive_t'(wdata); // see RQ11
      if (wr_prot)
        prot_q <= hbr_prot_t'(wdata); // see RQ12
      if (wr_out)
        outctl_q <= out_wr;
      if (wr_load)
        load_q <= hbr_load_t'(wdata); // see RQ14
      if (wr_out && out_wr.lock_code == HBR_LOCK_ON)
        locked_q <= 1'b1; // see RQ17
      else if (wr_out && out_wr.lock_code == HBR_LOCK_OFF)
        locked_q <= 1'b0;
    end
  end

  assign config_out = '{drive: drive_q, prot: prot_q, outctl: outctl_q, load: load_q};

  // ---------------- Status flags ----------------
  // Latched order: warn, supply, pump, thermal, load a, load b, oc ha, la, hb, lb
  logic [9:0] sticky_q;
  logic [1:0] regul_q;
  logic       fault_q;
  logic       fault_pin_n_q;

  wire logic       oc_on  = prot_q.overcurrent_response != HBR_OC_SILENT;
  wire logic [9:0] events = {det_s.overtemp_warning, det_s.supply_undervoltage,
                             det_s.pump_undervoltage & ~prot_q.pump_fault_disable,
                             det_s.thermal_shutdown, det_s.open_load_a, det_s.open_load_b,
                             {det_s.overcurrent_high_a, det_s.overcurrent_low_a,
                              det_s.overcurrent_high_b, det_s.overcurrent_low_b} & {4{oc_on}}};
  // Set wins over a clear in the same cycle
  wire logic [9:0] sticky_d = (sticky_q & {10{~clr_pls}}) | events; // see RQ16
  wire logic       tsd_bit  = prot_q.thermal_recovery_mode ? det_s.thermal_shutdown : sticky_q[6];
  wire logic       oc_any   = |sticky_q[3:0];
  wire logic       ol_any   = sticky_q[5] | sticky_q[4];
  wire logic       fault_d  = sticky_q[8] | sticky_q[7] | oc_any | tsd_bit | ol_any |
                              (prot_q.warning_report_enable & sticky_q[9]) |
                              (prot_q.trip_report_enable & (|regul_q));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sticky_q      <= 10'h000; // see RQ9
      regul_q       <= 2'h0;
      fault_q       <= 1'b0;
      fault_pin_n_q <= 1'b1;
    end else begin
      sticky_q      <= sticky_d;
      regul_q       <= {det_s.regulating_a, det_s.regulating_b}; // see RQ6, see RQ7
      fault_q       <= fault_d; // see RQ3
      fault_pin_n_q <= ~fault_d;
    end
  end

  assign fault_indication_pin_n = fault_pin_n_q;

  wire hbr_fault_t fault_live = '{reserved_bit: 1'b0, global_fault: fault_q, // see RQ2, see RQ3
                                  overtemp_warning_flag: sticky_q[9], supply_undervoltage_flag: sticky_q[8],
                                  pump_undervoltage_flag: sticky_q[7], overcurrent_flag: oc_any,
                                  thermal_shutdown_flag: tsd_bit, open_load_flag: ol_any}; // see RQ4
  wire hbr_diag_t diag_live = '{open_load_bridge_a: sticky_q[5], open_load_bridge_b: sticky_q[4], // see RQ5
                                regulating_bridge_a: regul_q[1], regulating_bridge_b: regul_q[0],
                                overcurrent_high_a: sticky_q[3], overcurrent_low_a: sticky_q[2],
                                overcurrent_high_b: sticky_q[1], overcurrent_low_b: sticky_q[0]}; // see RQ8

  // Snapshot for the link: frozen while a frame is open and for two cycles after cs_s rises, refreshed otherwise
  wire logic [7:0] live [0:HBR_NUM_REGS-1];
  assign live[0] = fault_live;
  assign live[1] = diag_live;
  assign live[2] = drive_q;
  assign live[3] = prot_q;
  assign live[4] = outctl_q;
  assign live[5] = load_q;

  wire logic snap_upd = cs_s & cs_prev_q & ~eval_q;

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < HBR_NUM_REGS; i++) begin
      if (rst)
        snap_q[i] <= 8'h00;
      else if (snap_upd)
        snap_q[i] <= live[i];
    end
  end

  // ---------------- Output steering ----------------
  hbr_bridge_t bridge_q;

  wire logic in_a = drive_q.serial_input_select ? outctl_q.serial_drive_bit_a : pin_a_s; // see RQ18
  wire logic in_b = drive_q.serial_input_select ? outctl_q.serial_drive_bit_b : pin_b_s;
  hbr_bridge_t bridge_d;

  always_comb begin
    bridge_d = '0;
    case (drive_q.control_mode) // see RQ15
      HBR_MODE_PH_EN:  bridge_d = '{a_driven: 1'b1, a_high: in_a & in_b, b_driven: 1'b1, b_high: in_a & ~in_b};
      HBR_MODE_TWO_IN: bridge_d = '{a_driven: 1'b1, a_high: in_a, b_driven: 1'b1, b_high: in_b};
      HBR_MODE_INDEP:  bridge_d = '{a_driven: ~outctl_q.bridge_a_disable, a_high: in_a,
                                    b_driven: ~outctl_q.bridge_b_disable, b_high: in_b};
      HBR_MODE_OFF:    bridge_d = '0;
      default:         bridge_d = '0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst)
      bridge_q <= '0;
    else
      bridge_q <= bridge_d;
  end

  assign bridge = bridge_q;

  // ---------------- Assertions ----------------
  a_fault_pin_mirror: assert property (@(posedge sys_clk) disable iff (rst) // see RQ3
    fault_q == ~fault_pin_n_q && !fault_live.reserved_bit) else $error("fault bit and pin disagree");
  a_clear_self_zero: assert property (@(posedge sys_clk) disable iff (rst) // see RQ16
    !outctl_q.fault_clear) else $error("fault clear bit read back as one");
  a_clear_empties: assert property (@(posedge sys_clk) disable iff (rst) // see RQ16
    clr_pls && events == 10'h000 |=> sticky_q == 10'h000) else $error("fault clear left a flag set");
  a_sticky_holds: assert property (@(posedge sys_clk) disable iff (rst) // see RQ8
    !clr_pls |=> (sticky_q & $past(sticky_q)) == $past(sticky_q)) else $error("latched flag dropped");
  a_lock_freezes: assert property (@(posedge sys_clk) disable iff (rst) // see RQ17
    locked_q && wr && waddr == HBR_ADDR_DRIVE |=> $stable(drive_q)) else $error("locked config changed");
  a_drive_write: assert property (@(posedge sys_clk) disable iff (rst) // see RQ11
    !locked_q && wr && waddr == HBR_ADDR_DRIVE |=> drive_q == $past(wdata)) else $error("config write lost");
  a_status_ignored: assert property (@(posedge sys_clk) disable iff (rst) // see RQ19
    wr && waddr <= HBR_ADDR_DIAG |=> $stable(drive_q) && $stable(prot_q) && $stable(outctl_q) && $stable(load_q))
    else $error("status write touched config");
  a_regul_a_live: assert property (@(posedge sys_clk) disable iff (rst) // see RQ6
    ##1 diag_live.regulating_bridge_a == $past(det_s.regulating_a)) else $error("output 1 regulation stale");
  a_regul_b_live: assert property (@(posedge sys_clk) disable iff (rst) // see RQ7
    ##1 diag_live.regulating_bridge_b == $past(det_s.regulating_b)) else $error("output 2 regulation stale");
  a_reset_status: assert property (@(posedge sys_clk) disable iff (1'b0) // see RQ9
    rst |=> fault_live == 8'h00 && diag_live == 8'h00) else $error("status not zero after reset");
  a_mode_hiz: assert property (@(posedge sys_clk) disable iff (rst) // see RQ15
    drive_q.control_mode == HBR_MODE_OFF |=> !bridge_q.a_driven && !bridge_q.b_driven)
    else $error("bridge driven while disabled");
  a_serial_follow: assert property (@(posedge sys_clk) disable iff (rst) // see RQ18
    drive_q.serial_input_select && drive_q.control_mode == HBR_MODE_TWO_IN
    |=> bridge_q.a_high == $past(outctl_q.serial_drive_bit_a) && bridge_q.b_high == $past(outctl_q.serial_drive_bit_b))
    else $error("outputs ignore serial bits");

endmodule // hbr_regs

// file: hw/hbr_sync.sv
// Two-stage level synchroniser into the sys_clk domain
`timescale 1ns/100ps
module hbr_sync #(
  parameter int unsigned WIDTH     = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // hbr_sync
